// ### common/dag_pkg.sv
// dag_pkg: shared widths, reset values and selector encodings for the address generators
// assumes a 14-bit address space and 16/24-bit data paths of the core
package dag_pkg;
  localparam int DAG_AW = 14;
  localparam int DAG_NREG = 4;
  localparam int DAG_SELW = 2;
  localparam int DAG_DW = 16;
  localparam int DAG_PW = 24;
  localparam int DAG_XW = 8;
  localparam logic [DAG_AW-1:0] DAG_ADDR_RST = 14'h0000;
  localparam logic [DAG_XW-1:0] DAG_PX_RST = 8'h00;
  localparam logic [DAG_PW-1:0] DAG_PMD_RST = 24'h000000;
  typedef enum logic [1:0] {
    DAG_WR_NONE,
    DAG_WR_I,
    DAG_WR_M,
    DAG_WR_L
  } dag_wr_t;
endpackage : dag_pkg

// ### rtl/dag_dual.sv
// dag_dual: two data address generators plus the program-memory extension path
// assumes the sequencer supplies one-cycle access strobes and register loads
// Function
// - each generator keeps and updates its own four index pointers
// - after an indirect access the pointer gets one selected modify value added
// - each pointer has a length; nonzero length makes a circular buffer
// - first generator drives data memory address only, optional bit reversal
// - second generator addresses program or data memory, no bit reversal
// - both generators can produce addresses in the same cycle when the second targets program memory
// - 16-bit writes to program memory take low eight bits from extension
// - data reads from program memory load low eight bits into extension
// - serial ports use the same circular pointer mechanism for auto transfers
`timescale 1ns/1ps
module dag_dual
  import dag_pkg::*;
#(
  parameter int AW = DAG_AW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic g1_acc,
  input wire logic [1:0] g1_isel,
  input wire logic [1:0] g1_msel,
  input wire logic g1_brev,
  input wire logic g2_acc,
  input wire logic [1:0] g2_isel,
  input wire logic [1:0] g2_msel,
  input wire logic g2_to_pm,
  input wire logic sp_acc,
  input wire logic [1:0] sp_isel,
  input wire logic [1:0] sp_msel,
  input wire logic wr_gen,
  input wire dag_wr_t wr_kind,
  input wire logic [1:0] wr_sel,
  input wire logic [AW-1:0] wr_val,
  input wire logic pm_wr,
  input wire logic [15:0] pm_wr_data,
  input wire logic pm_rd,
  input wire logic [23:0] pm_rd_data,
  input wire logic px_wr,
  input wire logic [7:0] px_wr_data,
  output logic [AW-1:0] dm_addr_q,
  output logic dm_addr_vld_q,
  output logic [AW-1:0] pm_addr_q,
  output logic pm_addr_vld_q,
  output logic [23:0] pm_data_out_q,
  output logic [7:0] px_q
);
  logic [AW-1:0] i1_q [DAG_NREG];
  logic [AW-1:0] m1_q [DAG_NREG];
  logic [AW-1:0] l1_q [DAG_NREG];
  logic [AW-1:0] b1_q [DAG_NREG];
  logic [AW-1:0] i2_q [DAG_NREG];
  logic [AW-1:0] m2_q [DAG_NREG];
  logic [AW-1:0] l2_q [DAG_NREG];
  logic [AW-1:0] b2_q [DAG_NREG];
  logic sp_go;

  // circular post-modify; base latched when the pointer is loaded
  function automatic logic [AW-1:0] post_mod(input logic [AW-1:0] i, input logic [AW-1:0] m,
                                               input logic [AW-1:0] l, input logic [AW-1:0] b);
    logic [AW:0] s;
    logic [AW:0] hi;
    s = {1'b0, i} + {m[AW-1], m};
    hi = {1'b0, b} + {1'b0, l};
    post_mod = s[AW-1:0];
    if (l != '0) begin
      if (m[AW-1] && (i + m) < b || (m[AW-1] && s[AW-1:0] > i)) begin
        post_mod = AW'(s[AW-1:0] + l);
      end else if (!m[AW-1] && {1'b0, s[AW-1:0]} >= hi) begin
        post_mod = AW'(s[AW-1:0] - l);
      end
    end
  endfunction : post_mod

  function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] a);
    for (int k = 0; k < AW; k++) begin
      bit_rev[k] = a[AW-1-k];
    end
  endfunction : bit_rev

  // serial port shares generator two, so a core access wins; limitation of one adder
  // serial words always go to data memory, whatever g2_to_pm says
  assign sp_go = sp_acc && !g2_acc;

  // generator one pointer file
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < DAG_NREG; k++) begin
        i1_q[k] <= DAG_ADDR_RST;
        m1_q[k] <= DAG_ADDR_RST;
        l1_q[k] <= DAG_ADDR_RST;
        b1_q[k] <= DAG_ADDR_RST;
      end
    end else begin
      if (g1_acc) begin
        i1_q[g1_isel] <= post_mod(i1_q[g1_isel], m1_q[g1_msel], l1_q[g1_isel],
                                  b1_q[g1_isel]);
      end
      if (!wr_gen && wr_kind == DAG_WR_I) begin
        i1_q[wr_sel] <= wr_val;
        b1_q[wr_sel] <= wr_val;
      end
      if (!wr_gen && wr_kind == DAG_WR_M) begin
        m1_q[wr_sel] <= wr_val;
      end
      if (!wr_gen && wr_kind == DAG_WR_L) begin
        l1_q[wr_sel] <= wr_val;
      end
    end
  end

  // generator two pointer file, also used by serial port autobuffering
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < DAG_NREG; k++) begin
        i2_q[k] <= DAG_ADDR_RST;
        m2_q[k] <= DAG_ADDR_RST;
        l2_q[k] <= DAG_ADDR_RST;
        b2_q[k] <= DAG_ADDR_RST;
      end
    end else begin
      if (g2_acc) begin
        i2_q[g2_isel] <= post_mod(i2_q[g2_isel], m2_q[g2_msel], l2_q[g2_isel],
                                  b2_q[g2_isel]);
      end else if (sp_acc) begin
        i2_q[sp_isel] <= post_mod(i2_q[sp_isel], m2_q[sp_msel], l2_q[sp_isel],
                                  b2_q[sp_isel]);
      end
      if (wr_gen && wr_kind == DAG_WR_I) begin
        i2_q[wr_sel] <= wr_val;
        b2_q[wr_sel] <= wr_val;
      end
      if (wr_gen && wr_kind == DAG_WR_M) begin
        m2_q[wr_sel] <= wr_val;
      end
      if (wr_gen && wr_kind == DAG_WR_L) begin
        l2_q[wr_sel] <= wr_val;
      end
    end
  end

  // address outputs; dm bus prefers generator one when both target it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dm_addr_q <= DAG_ADDR_RST;
      dm_addr_vld_q <= 1'b0;
      pm_addr_q <= DAG_ADDR_RST;
      pm_addr_vld_q <= 1'b0;
    end else begin
      dm_addr_vld_q <= g1_acc || (g2_acc && !g2_to_pm) || sp_go;
      pm_addr_vld_q <= g2_acc && g2_to_pm;
      if (g1_acc) begin
        dm_addr_q <= g1_brev ? bit_rev(i1_q[g1_isel]) : i1_q[g1_isel];
      end else if (g2_acc && !g2_to_pm) begin
        dm_addr_q <= i2_q[g2_isel];
      end else if (sp_go) begin
        dm_addr_q <= i2_q[sp_isel];
      end
      if (g2_acc && g2_to_pm) begin
        pm_addr_q <= i2_q[g2_isel];
      end
    end
  end

  // extension register; a data read beats a direct load in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      px_q <= DAG_PX_RST;
      pm_data_out_q <= DAG_PMD_RST;
    end else begin
      if (pm_rd) begin
        px_q <= pm_rd_data[7:0];
      end else if (px_wr) begin
        px_q <= px_wr_data;
      end
      if (pm_wr) begin
        pm_data_out_q <= {pm_wr_data, px_q};
      end
    end
  end

  property p_pm_wr_ext;
    @(posedge clk) disable iff (!rstn) pm_wr |=> pm_data_out_q[7:0] == $past(px_q);
  endproperty
  a_pm_wr_ext: assert property (p_pm_wr_ext) else $error("extension low bits wrong");
  property p_pm_rd_ext;
    @(posedge clk) disable iff (!rstn) pm_rd |=> px_q == $past(pm_rd_data[7:0]);
  endproperty
  a_pm_rd_ext: assert property (p_pm_rd_ext) else $error("extension not loaded");
  property p_g1_dm;
    @(posedge clk) disable iff (!rstn) g1_acc && !g1_brev |=> dm_addr_vld_q
      && dm_addr_q == $past(i1_q[g1_isel]);
  endproperty
  a_g1_dm: assert property (p_g1_dm) else $error("gen one address wrong");
  property p_g1_rev;
    @(posedge clk) disable iff (!rstn) g1_acc && g1_brev |=>
      dm_addr_q == bit_rev($past(i1_q[g1_isel]));
  endproperty
  a_g1_rev: assert property (p_g1_rev) else $error("bit reversal wrong");
  property p_g2_pm;
    @(posedge clk) disable iff (!rstn) g2_acc && g2_to_pm |=> pm_addr_vld_q
      && pm_addr_q == $past(i2_q[g2_isel]);
  endproperty
  a_g2_pm: assert property (p_g2_pm) else $error("gen two pm address wrong");
  property p_dual;
    @(posedge clk) disable iff (!rstn) g1_acc && g2_acc && g2_to_pm |=>
      dm_addr_vld_q && pm_addr_vld_q;
  endproperty
  a_dual: assert property (p_dual) else $error("dual fetch lost");
  property p_linear;
    @(posedge clk) disable iff (!rstn) g1_acc && l1_q[g1_isel] == '0 && !wr_gen
      |=> i1_q[$past(g1_isel)] == AW'($past(i1_q[g1_isel]) + $past(m1_q[g1_msel]))
      || $past(wr_kind) == DAG_WR_I;
  endproperty
  a_linear: assert property (p_linear) else $error("linear update wrong");
  property p_g2_lin;
    @(posedge clk) disable iff (!rstn) g2_acc && l2_q[g2_isel] == '0 && wr_kind == DAG_WR_NONE
      |=> i2_q[$past(g2_isel)] == AW'($past(i2_q[g2_isel]) + $past(m2_q[g2_msel]));
  endproperty
  a_g2_lin: assert property (p_g2_lin) else $error("gen two update wrong");
  property p_sp_dm;
    @(posedge clk) disable iff (!rstn) sp_acc && !g2_acc && !g1_acc |=> dm_addr_vld_q
      && dm_addr_q == $past(i2_q[sp_isel]);
  endproperty
  a_sp_dm: assert property (p_sp_dm) else $error("serial address wrong");
  c_dual: cover property (@(posedge clk) disable iff (!rstn) g1_acc && g2_acc && g2_to_pm);
  c_circ: cover property (@(posedge clk) disable iff (!rstn) g1_acc && l1_q[g1_isel] != '0);
  c_sport: cover property (@(posedge clk) disable iff (!rstn) sp_acc && !g2_acc);
endmodule : dag_dual

// ### testbench/dag_mem_model.sv
// dag_mem_model: program memory read side facing the generators
// assumes the word is taken one cycle after the address pulse
`timescale 1ns/1ps
module dag_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [13:0] addr,
  input wire logic vld,
  output logic [23:0] rd_data
);
  // stale word is inverted each cycle, so a sample an odd number of cycles late never matches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rd_data <= 24'h000000;
    else if (vld) rd_data <= {2'h0, addr, addr[7:0] ^ 8'h5a};
    else rd_data <= ~rd_data;
  end
endmodule : dag_mem_model

// ### testbench/tb_top.sv
// tb_top: corner cases and seeded random traffic for both generators
// assumes each answer lands one cycle after its strobe
`timescale 1ns/1ps
module tb_top;
  import dag_pkg::*;
  logic clk = 1'b0;
  logic rstn, g1_acc, g1_brev, g2_acc, g2_to_pm, sp_acc, wr_gen, pm_wr, pm_rd, px_wr;
  logic [1:0] g1_isel, g1_msel, g2_isel, g2_msel, sp_isel, sp_msel, wr_sel;
  logic [13:0] wr_val, dm_addr_q, pm_addr_q, ri[2][4], rm[2][4], rl[2][4], rb[2][4];
  logic [15:0] pm_wr_data;
  logic [23:0] pm_rd_data, pm_data_out_q;
  logic [7:0] px_wr_data, px_q;
  logic dm_addr_vld_q, pm_addr_vld_q;
  dag_wr_t wr_kind;
  int fail_count, compares, g, l;
  dag_dual u_dag_dual (.clk(clk), .rstn(rstn), .g1_acc(g1_acc), .g1_isel(g1_isel),
    .g1_msel(g1_msel), .g1_brev(g1_brev), .g2_acc(g2_acc), .g2_isel(g2_isel),
    .g2_msel(g2_msel), .g2_to_pm(g2_to_pm), .sp_acc(sp_acc), .sp_isel(sp_isel),
    .sp_msel(sp_msel), .wr_gen(wr_gen), .wr_kind(wr_kind), .wr_sel(wr_sel), .wr_val(wr_val),
    .pm_wr(pm_wr), .pm_wr_data(pm_wr_data), .pm_rd(pm_rd), .pm_rd_data(pm_rd_data),
    .px_wr(px_wr), .px_wr_data(px_wr_data), .dm_addr_q(dm_addr_q),
    .dm_addr_vld_q(dm_addr_vld_q), .pm_addr_q(pm_addr_q), .pm_addr_vld_q(pm_addr_vld_q),
    .pm_data_out_q(pm_data_out_q), .px_q(px_q));
  dag_mem_model u_dag_mem_model (.clk(clk), .rstn(rstn), .addr(pm_addr_q),
    .vld(pm_addr_vld_q), .rd_data(pm_rd_data));
  initial forever #5 clk = ~clk;
  task automatic chk(logic [23:0] got, logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  function automatic logic [13:0] post(int x, int k);
    int n = int'(ri[x][k]) + int'($signed(rm[x][k]));
    int b = int'(rb[x][k]);
    int w = int'(rl[x][k]);
    if (w != 0 && !rm[x][k][13] && n >= b + w) n -= w;
    if (w != 0 && rm[x][k][13] && n < b) n += w;
    return n[13:0];
  endfunction : post
  task automatic drive(logic [5:0] st, dag_wr_t k);
    {g1_acc, g2_acc, sp_acc, pm_wr, pm_rd, px_wr} = st;
    wr_kind = k;
    @(posedge clk);
    #1;
  endtask : drive
  task automatic ld(bit x, dag_wr_t k, logic [1:0] s, logic [13:0] v);
    {wr_gen, wr_sel, wr_val} = {x, s, v};
    drive(6'h00, k);
    if (k == DAG_WR_I) {ri[x][s], rb[x][s]} = {v, v};
    if (k == DAG_WR_M) rm[x][s] = v;
    if (k == DAG_WR_L) rl[x][s] = v;
  endtask : ld
  task automatic acc(bit a1, bit a2, bit sp, bit br, bit pm, logic [1:0] i1, logic [1:0] i2);
    logic [13:0] r;
    bit v;
    {g1_isel, g1_msel, g1_brev, sp_isel, sp_msel} = {i1, i1, br, i2, i2};
    {g2_isel, g2_msel, g2_to_pm} = {i2, i2, pm};
    drive({a1, a2, sp, 3'h0}, DAG_WR_NONE);
    v = a1 | (a2 & !pm) | (sp & !a2);
    r = {<<{ri[0][i1]}};
    if (!br) r = ri[0][i1];
    if (!a1) r = ri[1][i2];
    chk({dm_addr_vld_q, pm_addr_vld_q}, {v, a2 & pm});
    if (v) chk(dm_addr_q, r);
    if (a2 & pm) chk(pm_addr_q, ri[1][i2]);
    if (a1) ri[0][i1] = post(0, i1);
    if (a2 | sp) ri[1][i2] = post(1, i2);
  endtask : acc
  initial begin
    {rstn, g1_isel, g1_msel, g1_brev, g2_isel, g2_msel, g2_to_pm, sp_isel, sp_msel} = '0;
    {g1_acc, g2_acc, sp_acc, pm_wr, pm_rd, px_wr, wr_gen, wr_sel, wr_val} = '0;
    {pm_wr_data, px_wr_data, fail_count, compares} = '0;
    wr_kind = DAG_WR_NONE;
    foreach (ri[i, j]) {ri[i][j], rm[i][j], rl[i][j], rb[i][j]} = '0;
    void'($urandom(32'h82b2ead2));
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({dm_addr_q, px_q}, '0);
    ld(0, DAG_WR_I, 2'h0, 14'h0005);
    ld(0, DAG_WR_M, 2'h0, 14'h0003);
    repeat (2) acc(1, 0, 0, 0, 0, 2'h0, 2'h0);
    ld(1, DAG_WR_I, 2'h1, 14'h0010);
    ld(1, DAG_WR_L, 2'h1, 14'h0004);
    ld(1, DAG_WR_M, 2'h1, 14'h0003);
    repeat (4) acc(0, 1, 0, 0, 1, 2'h0, 2'h1);
    ld(1, DAG_WR_M, 2'h1, 14'h3ffd);
    repeat (4) acc(0, 1, 0, 0, 1, 2'h0, 2'h1);
    $display("buffer tests done");
    ld(0, DAG_WR_I, 2'h2, 14'h0001);
    acc(1, 1, 0, 1, 1, 2'h2, 2'h1);
    acc(0, 0, 1, 0, 0, 2'h0, 2'h1);
    acc(0, 1, 1, 0, 0, 2'h0, 2'h1);
    // serial word while generator two is steered at program memory
    acc(0, 0, 1, 0, 1, 2'h0, 2'h1);
    $display("dual and serial tests done");
    {pm_wr_data, px_wr_data} = {16'($urandom), 8'ha5};
    drive(6'h01, DAG_WR_NONE);
    drive(6'h04, DAG_WR_NONE);
    chk(pm_data_out_q, {pm_wr_data, 8'ha5});
    acc(0, 1, 0, 0, 1, 2'h0, 2'h3);
    drive(6'h00, DAG_WR_NONE);
    // extension load and read land together: the read must win
    drive(6'h03, DAG_WR_NONE);
    chk(px_q, ri[1][3][7:0] ^ 8'h5a);
    $display("extension tests done");
    foreach (ri[i, j]) begin
      l = $urandom_range(0, 12);
      ld(i[0], DAG_WR_L, 2'(j), 14'(l));
      ld(i[0], DAG_WR_I, 2'(j), 14'($urandom_range(0, 4000)));
      l = (l != 0) ? l : 3;
      ld(i[0], DAG_WR_M, 2'(j), 14'(int'($urandom_range(0, 2 * l)) - l));
    end
    repeat (400) begin
      g = $urandom;
      acc(g[0], g[1], g[2] & !g[0], g[3], g[4] | g[0], 2'(g[6:5]), 2'(g[8:7]));
    end
    $display("random tests done");
    wrap_up();
  end
endmodule : tb_top
